// ===== drive_ctl_pkg.sv
// Purpose: shared constants for the drive-side control cable logic
// Assumes: 100 MHz core clock, cable lines true when low
// Notes:   input vector layout matches the synchroniser bank in the top
package drive_ctl_pkg;

	// Clock and timing
	localparam int CLK_MHZ  = 100;
	localparam int QUIET_US = 50;  // Step train counted as ended after this
	localparam int QUIET_CYC = QUIET_US * CLK_MHZ;

	// Travel limits
	localparam int TRK_W  = 11;
	localparam int PEND_W = 13;
	localparam logic [TRK_W-1:0] INNER_SMALL = 11'd1003;
	localparam logic [TRK_W-1:0] INNER_LARGE = 11'd1167;
	localparam logic [TRK_W-1:0] TRK_RST     = 11'h000;

	// Positions in the synchronised input vector
	localparam int IN_SEL_N  = 0;   // Four unit select lines
	localparam int IN_HEAD_N = 4;   // Three head select lines
	localparam int IN_WE_N   = 7;
	localparam int IN_STEP_N = 8;
	localparam int IN_DIR    = 9;   // High means outward
	localparam int IN_TRK0   = 10;
	localparam int IN_OFFTRK = 11;
	localparam int IN_HOPEN  = 12;
	localparam int IN_HSHORT = 13;
	localparam int IN_WCUR   = 14;
	localparam int IN_SUPPLY = 15;
	localparam int IN_SPEED  = 16;
	localparam int IN_INDEX_N = 17;
	localparam int IN_ACTDONE = 18;
	localparam int IN_CFG    = 19;  // Two bits
	localparam int IN_LARGE  = 21;
	localparam int IN_W      = 22;
	localparam logic [IN_W-1:0] SYNC_INIT = 22'h0203FF;

	// Positions of the open-collector status lines
	localparam int ST_SETTLED = 0;
	localparam int ST_OUTER   = 1;
	localparam int ST_UNSAFE  = 2;
	localparam int ST_INDEX   = 3;
	localparam int ST_READY   = 4;
	localparam int ST_W       = 5;
	localparam logic [ST_W-1:0] ST_OE_RST = 5'h1F;

	// Positioner states
	typedef enum logic [4:0] {
		S_RECAL  = 5'b00001,
		S_IDLE   = 5'b00010,
		S_GATHER = 5'b00100,
		S_MOVE   = 5'b01000,
		S_ARRIVE = 5'b10000
	} pos_state_e;

endpackage

// ===== sync_two.sv
// Purpose: two-flop synchroniser bank for cable and sensor inputs
// Assumes: inputs are levels from outside the clock domain
// Notes:   reset value per bit given by INIT
`timescale 1ns/1ns
`default_nettype none
module sync_two #(
	parameter int              W    = 1,
	parameter logic [W-1:0]    INIT = '0
) (
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rstn,
	// Data
	input  wire logic [W-1:0]  d,
	output logic      [W-1:0]  q
);

	logic [W-1:0] meta_q;

	// Two stages; only the second stage is seen outside
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= INIT;
			q      <= INIT;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ===== drive_ctl.sv
// Purpose: drive-side control cable logic: select, heads, seek, status
// Assumes: all cable and sensor inputs asynchronous; servo answers
//          each actuator step request with a done level
// Notes:   status lines are open collector, driven low when enabled
`timescale 1ns/1ns
`default_nettype none
module drive_ctl
	import drive_ctl_pkg::*;
#(
	parameter int QUIET_CYCLES = QUIET_CYC
) (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              RSTN,
	// Host control cable, all true when low
	input  wire logic [3:0]        UNIT_SEL_N,
	input  wire logic [2:0]        HEAD_SEL_N,
	input  wire logic              WRITE_ENABLE_IN_N,
	input  wire logic              STEP_N,
	input  wire logic              HEAD_MOVE_INWARD_N,
	// Configuration straps
	input  wire logic [1:0]        SELECT_CFG,
	input  wire logic              MODEL_LARGE,
	// Drive sensors
	input  wire logic              TRACK0_SENSE,
	input  wire logic              OFF_TRACK,
	input  wire logic              HEAD_OPEN,
	input  wire logic              HEAD_SHORT,
	input  wire logic              WRITE_CURRENT_OK,
	input  wire logic              SUPPLY_OK,
	input  wire logic              SPEED_OK,
	input  wire logic              INDEX_SENSE_N,
	// Actuator handshake
	input  wire logic              ACT_DONE,
	output logic                   ACT_STEP,
	output logic                   ACT_DIR_IN,
	// Read/write channel control
	output logic [2:0]             HEAD_NUM,
	output logic                   WRITE_MODE,
	output logic                   WRITE_DRIVE,
	// Status lines: settled, outer, unsafe, index, ready
	output logic [ST_W-1:0]        STAT_OUT,
	output logic [ST_W-1:0]        STAT_OE_N
);

	logic [IN_W-1:0]   raw;
	logic [IN_W-1:0]   s;
	pos_state_e        state_q;
	logic [TRK_W-1:0]  track_q;
	logic [TRK_W-1:0]  target_q;
	logic [PEND_W-1:0] pend_q;
	logic [15:0]       quiet_q;
	logic              step_prev_q;
	logic              done_prev_q;
	logic              busy_q;
	logic              fault_q;
	logic              settled_q;
	logic              ready_q;
	logic              selected;
	logic              accept;
	logic              we_host;
	logic              we_cmd;
	logic              step_ev;
	logic              done_ev;
	logic              quiet_done;
	logic              power_ok;
	logic              bad_write;
	logic [TRK_W-1:0]  limit;
	logic [ST_W-1:0]   flags;

	// Clamp current track plus pending steps into the travel range
	function automatic logic [TRK_W-1:0] clamp_trk(
		input logic [TRK_W-1:0]  trk,
		input logic [PEND_W-1:0] pend,
		input logic [TRK_W-1:0]  lim
	);
		logic signed [PEND_W:0] sum;
		sum = $signed({2'b00, trk}) + $signed({pend[PEND_W-1], pend});
		if (sum < 0)
			clamp_trk = '0;
		else if (sum > $signed({3'b000, lim}))
			clamp_trk = lim;
		else
			clamp_trk = sum[TRK_W-1:0];
	endfunction

	// Saturating add of one signed step to the pending count
	function automatic logic [PEND_W-1:0] pend_add(
		input logic [PEND_W-1:0] pend,
		input logic              outward
	);
		logic signed [PEND_W-1:0] p;
		p = $signed(pend);
		if (outward)
			pend_add = (p == -(2 ** (PEND_W - 1))) ? pend : pend - 1'b1;
		else
			pend_add = (p == (2 ** (PEND_W - 1)) - 1) ? pend : pend + 1'b1;
	endfunction

	// Gather every asynchronous input into one synchroniser bank
	assign raw = {MODEL_LARGE, SELECT_CFG, ACT_DONE, INDEX_SENSE_N,
		SPEED_OK, SUPPLY_OK, WRITE_CURRENT_OK, HEAD_SHORT, HEAD_OPEN,
		OFF_TRACK, TRACK0_SENSE, HEAD_MOVE_INWARD_N, STEP_N,
		WRITE_ENABLE_IN_N, HEAD_SEL_N, UNIT_SEL_N};

	sync_two #(
		.W    (IN_W),
		.INIT (SYNC_INIT)
	) u_sync (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (raw),
		.q    (s)
	);

	// Selection and command gating
	assign selected = !s[IN_SEL_N + s[IN_CFG +: 2]];
	assign accept   = selected && !fault_q;
	assign we_host  = selected && !s[IN_WE_N];
	assign we_cmd   = accept && !s[IN_WE_N];
	assign step_ev  = accept && step_prev_q && !s[IN_STEP_N];
	assign done_ev  = s[IN_ACTDONE] && !done_prev_q;
	assign power_ok = s[IN_SUPPLY] && s[IN_SPEED];
	assign limit    = s[IN_LARGE] ? INNER_LARGE : INNER_SMALL;
	assign quiet_done = (quiet_q >= 16'(QUIET_CYCLES));

	// Conditions that make writing unsafe
	assign bad_write = s[IN_HOPEN] || s[IN_HSHORT] || !s[IN_WCUR]
		|| s[IN_OFFTRK] || !settled_q || !ready_q;

	// Edge detectors on second-stage synchroniser outputs
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			step_prev_q <= 1'b1;
			done_prev_q <= 1'b0;
		end else begin
			step_prev_q <= s[IN_STEP_N];
			done_prev_q <= s[IN_ACTDONE];
		end
	end

	// Time since the last accepted step pulse
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			quiet_q <= 16'h0000;
		end else if (step_ev) begin
			quiet_q <= 16'h0000;
		end else if (!quiet_done) begin
			quiet_q <= quiet_q + 16'h0001;
		end
	end

	// Pending step count; direction sampled with each step
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pend_q <= '0;
		end else if (state_q == S_RECAL) begin
			pend_q <= '0;
		end else if (state_q == S_GATHER && quiet_done) begin
			pend_q <= step_ev ? pend_add('0, s[IN_DIR]) : '0;
		end else if (step_ev) begin
			pend_q <= pend_add(pend_q, s[IN_DIR]);
		end
	end

	// Positioner state machine
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_q  <= S_RECAL;
			target_q <= TRK_RST;
		end else if (!power_ok) begin
			state_q  <= S_RECAL;
		end else begin
			case (state_q)
				S_RECAL: begin
					if (s[IN_TRK0] && !busy_q) begin
						state_q  <= S_IDLE;
						target_q <= TRK_RST;
					end
				end
				S_IDLE: begin
					if (pend_q != '0)
						state_q <= S_GATHER;
				end
				S_GATHER: begin
					if (quiet_done) begin
						target_q <= clamp_trk(track_q, pend_q,
							limit);
						state_q  <= S_MOVE;
					end
				end
				S_MOVE: begin
					if (track_q == target_q && !busy_q)
						state_q <= S_ARRIVE;
				end
				S_ARRIVE: begin
					if (target_q == TRK_RST && !s[IN_TRK0])
						state_q <= S_RECAL;
					else if (pend_q != '0)
						state_q <= S_GATHER;
					else
						state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_RECAL;
				end
			endcase
		end
	end

	// Actuator requests, one track each, waiting for the servo
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			busy_q     <= 1'b0;
			ACT_STEP   <= 1'b0;
			ACT_DIR_IN <= 1'b0;
		end else begin
			ACT_STEP <= 1'b0;
			if (busy_q) begin
				if (done_ev)
					busy_q <= 1'b0;
			end else if (state_q == S_RECAL && !s[IN_TRK0]
				&& power_ok) begin
				ACT_STEP   <= 1'b1;
				ACT_DIR_IN <= 1'b0;
				busy_q     <= 1'b1;
			end else if (state_q == S_MOVE && track_q != target_q) begin
				ACT_STEP   <= 1'b1;
				ACT_DIR_IN <= (target_q > track_q);
				busy_q     <= 1'b1;
			end
		end
	end

	// Track position follows completed actuator steps
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			track_q <= TRK_RST;
		end else if (state_q == S_RECAL && s[IN_TRK0]) begin
			track_q <= TRK_RST;
		end else if (busy_q && done_ev && state_q == S_MOVE) begin
			if (ACT_DIR_IN)
				track_q <= track_q + 11'h001;
			else if (track_q != TRK_RST)
				track_q <= track_q - 11'h001;
		end
	end

	// Heads settled: idle, nothing pending, no step, no disturbance
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			settled_q <= 1'b0;
		end else begin
			settled_q <= (state_q == S_IDLE) && (pend_q == '0)
				&& !step_ev
				&& power_ok
				&& !(s[IN_OFFTRK] && selected);
		end
	end

	// Ready after recalibration with supply and speed good
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ready_q <= 1'b0;
		end else if (!power_ok || state_q == S_RECAL) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= 1'b1;
		end
	end

	// Write fault latches until reset and locks out commands
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			fault_q <= 1'b0;
		end else if (we_cmd && (bad_write || s[IN_HEAD_N +: 3] == 3'h0)) begin
			fault_q <= 1'b1;
		end
	end

	// Read/write channel: head number and internal write enable
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			HEAD_NUM    <= 3'h0;
			WRITE_MODE  <= 1'b0;
			WRITE_DRIVE <= 1'b0;
		end else begin
			if (accept)
				HEAD_NUM <= ~s[IN_HEAD_N +: 3];
			WRITE_MODE  <= we_cmd;
			WRITE_DRIVE <= we_cmd && !bad_write
				&& s[IN_HEAD_N +: 3] != 3'h0;
		end
	end

	// Status line levels before select gating
	always_comb begin
		flags             = '0;
		flags[ST_SETTLED] = settled_q;
		flags[ST_OUTER]   = (track_q == TRK_RST)
			&& state_q != S_RECAL;
		flags[ST_UNSAFE]  = fault_q && we_host;
		flags[ST_INDEX]   = !s[IN_INDEX_N];
		flags[ST_READY]   = ready_q;
	end

	// Open-collector drivers enabled only for the selected unit
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			STAT_OUT  <= '0;
			STAT_OE_N <= ST_OE_RST;
		end else begin
			STAT_OUT  <= '0;
			STAT_OE_N <= ~(flags & {ST_W{selected}});
		end
	end

endmodule
`default_nettype wire

// ===== drive_ctl_sva.sv
// Purpose: port assertions for the drive control cable block
// Assumes: one clock domain, cable inputs pass two sync flops
// Notes:   output figures allow the sync and register latency
`timescale 1ns/1ns
`default_nettype none
module drive_ctl_sva
	import drive_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic            CLK,
	input  wire logic            RSTN,
	// Cable, strap and index sensor inputs
	input  wire logic [3:0]      UNIT_SEL_N,
	input  wire logic [2:0]      HEAD_SEL_N,
	input  wire logic            WRITE_ENABLE_IN_N,
	input  wire logic            STEP_N,
	input  wire logic [1:0]      SELECT_CFG,
	input  wire logic            INDEX_SENSE_N,
	// Watched outputs
	input  wire logic            ACT_STEP,
	input  wire logic            ACT_DIR_IN,
	input  wire logic [2:0]      HEAD_NUM,
	input  wire logic            WRITE_DRIVE,
	input  wire logic [ST_W-1:0] STAT_OE_N
);
	logic sel;
	logic flt_q;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Our select line is true when low
	assign sel = !UNIT_SEL_N[SELECT_CFG];
	// Set once a write fault has shown; commands are dead after it
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN)
			flt_q <= 1'b0;
		else if (!STAT_OE_N[ST_UNSAFE])
			flt_q <= 1'b1;
	end
	property p_unsel;
		(!sel)[*4] |-> STAT_OE_N == 5'h1F;
	endproperty
	a_unsel: assert property (p_unsel)
		else $error("status driven while unselected");
	property p_drop;
		sel[*3] ##1 (sel && $fell(STEP_N) && !flt_q)
			|-> ##[1:5] STAT_OE_N[ST_SETTLED];
	endproperty
	a_drop: assert property (p_drop)
		else $error("settled not dropped after step");
	property p_pulse;
		ACT_STEP |=> !ACT_STEP [*3];
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("actuator requests too close");
	property p_busy;
		ACT_STEP |-> STAT_OE_N[ST_SETTLED];
	endproperty
	a_busy: assert property (p_busy)
		else $error("settled shown while moving");
	property p_dir;
		ACT_STEP && !STAT_OE_N[ST_OUTER] |-> ACT_DIR_IN;
	endproperty
	a_dir: assert property (p_dir)
		else $error("outward step from track zero");
	property p_head;
		(sel && !flt_q && $stable(HEAD_SEL_N))[*5] |-> HEAD_NUM == ~HEAD_SEL_N;
	endproperty
	a_head: assert property (p_head)
		else $error("head number wrong");
	property p_wdrv;
		(WRITE_ENABLE_IN_N || !sel)[*5] |-> !WRITE_DRIVE;
	endproperty
	a_wdrv: assert property (p_wdrv)
		else $error("writing without write enable");
	property p_unsafe;
		WRITE_ENABLE_IN_N[*5] |-> STAT_OE_N[ST_UNSAFE];
	endproperty
	a_unsafe: assert property (p_unsafe)
		else $error("unsafe flag without write enable");
	property p_cut;
		$fell(STAT_OE_N[ST_UNSAFE]) |-> ##[0:4] !WRITE_DRIVE;
	endproperty
	a_cut: assert property (p_cut)
		else $error("write not cut on fault");
	property p_index;
		(sel && !INDEX_SENSE_N)[*5] |-> !STAT_OE_N[ST_INDEX];
	endproperty
	a_index: assert property (p_index)
		else $error("index not shown");
	// Main scenarios reached
	c_step: cover property (ACT_STEP);
	c_fault: cover property (!STAT_OE_N[ST_UNSAFE]);
	c_outer: cover property (!STAT_OE_N[ST_OUTER]);
endmodule
bind drive_ctl drive_ctl_sva u_drive_ctl_sva (.CLK, .RSTN, .UNIT_SEL_N,
	.HEAD_SEL_N, .WRITE_ENABLE_IN_N, .STEP_N, .SELECT_CFG, .INDEX_SENSE_N,
	.ACT_STEP, .ACT_DIR_IN, .HEAD_NUM, .WRITE_DRIVE, .STAT_OE_N);
`default_nettype wire

// ===== host_model.sv
// Purpose: host controller driving the shared control cable
// Assumes: cable lines are terminated, so idle lines read high
// Notes:   the bench sets select and head lines directly
`timescale 1ns/1ns
`default_nettype none
module host_model
(
	// Clock and status lines
	input  wire logic       clk,
	input  wire logic [4:0] stat_oe_n,
	// Cable lines toward the drive
	output logic [3:0]      unit_sel_n,
	output logic [2:0]      head_sel_n,
	output logic            we_n,
	output logic            step_n,
	output logic            dir_n
);
	logic fault_q;
	// Idle cable, except unit select line 2 held low
	initial begin
		unit_sel_n = 4'hB;
		head_sel_n = 3'h7;
		we_n = 1'b1;
		step_n = 1'b1;
		dir_n = 1'b1;
		fault_q = 1'b0;
	end
	// The fault flag may vanish, so its edge is caught and held
	always @(posedge clk) begin
		if (!stat_oe_n[2])
			fault_q <= 1'b1;
	end
	// Buffered step train, 50 ns period, well under 39 us
	task automatic steps(input int n, input logic outward);
		@(posedge clk) #1 dir_n = outward;
		repeat (n) begin
			@(posedge clk) #1 step_n = 1'b0;
			repeat (2) @(posedge clk);
			#1 step_n = 1'b1;
			repeat (2) @(posedge clk);
		end
	endtask
	// Write once settled and ready, or after a 100-cycle wait; ok tells which
	task automatic write_on(output bit ok);
		for (int i = 0; i < 100 && (stat_oe_n[0] || stat_oe_n[4]); i++)
			@(posedge clk);
		ok = !(stat_oe_n[0] || stat_oe_n[4]);
		@(posedge clk) #1 we_n = 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Purpose: self-checking bench for the drive control cable block
// Assumes: servo answers each step request a few cycles later
// Notes:   quiet time shortened to 20 cycles
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import drive_ctl_pkg::*;
;
	logic CLK, RSTN, MODEL_LARGE, OFF_TRACK, HEAD_OPEN, HEAD_SHORT;
	logic WRITE_CURRENT_OK, SUPPLY_OK, SPEED_OK, INDEX_SENSE_N, ACT_DONE;
	logic ACT_STEP, ACT_DIR_IN, WRITE_MODE, WRITE_DRIVE;
	logic [1:0] SELECT_CFG;
	logic [2:0] HEAD_NUM;
	logic [ST_W-1:0] STAT_OUT, STAT_OE_N;
	wire logic [3:0] sel_n;
	wire logic [2:0] head_n;
	wire logic we_n, step_n, dir_n;
	int phys, failures, n_tests;
	drive_ctl #(.QUIET_CYCLES(20)) u_drive_ctl (.CLK(CLK), .RSTN(RSTN),
		.UNIT_SEL_N(sel_n), .HEAD_SEL_N(head_n), .WRITE_ENABLE_IN_N(we_n),
		.STEP_N(step_n), .HEAD_MOVE_INWARD_N(dir_n), .SELECT_CFG(SELECT_CFG),
		.MODEL_LARGE(MODEL_LARGE), .TRACK0_SENSE(phys == 0),
		.OFF_TRACK(OFF_TRACK), .HEAD_OPEN(HEAD_OPEN), .HEAD_SHORT(HEAD_SHORT),
		.WRITE_CURRENT_OK(WRITE_CURRENT_OK), .SUPPLY_OK(SUPPLY_OK),
		.SPEED_OK(SPEED_OK), .INDEX_SENSE_N(INDEX_SENSE_N),
		.ACT_DONE(ACT_DONE), .ACT_STEP(ACT_STEP), .ACT_DIR_IN(ACT_DIR_IN),
		.HEAD_NUM(HEAD_NUM), .WRITE_MODE(WRITE_MODE),
		.WRITE_DRIVE(WRITE_DRIVE), .STAT_OUT(STAT_OUT), .STAT_OE_N(STAT_OE_N));
	host_model u_host_model (.clk(CLK), .stat_oe_n(STAT_OE_N),
		.unit_sel_n(sel_n), .head_sel_n(head_n), .we_n(we_n),
		.step_n(step_n), .dir_n(dir_n));
	// 100 MHz clock
	always #5 CLK = ~CLK;
	// Servo moves the heads and answers each request with a done level
	always @(posedge CLK) begin
		if (ACT_STEP) begin
			#1 phys = ACT_DIR_IN ? phys + 1 : phys - 1;
			repeat (3) @(posedge CLK);
			#1 ACT_DONE = 1'b1;
			repeat (2) @(posedge CLK);
			#1 ACT_DONE = 1'b0;
		end
	end
	task automatic wrap_up();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic wait_settled();
		int i;
		for (i = 0; i < 20000 && STAT_OE_N[0] !== 1'b0; i++)
			@(posedge CLK);
		if (i == 20000) begin
			failures++;
			wrap_up();
		end
	endtask
	// Write request once settled and ready; a timeout ends the run
	task automatic host_write();
		bit ok;
		u_host_model.write_on(ok);
		if (!ok) begin
			failures++;
			wrap_up();
		end
	endtask
	task automatic do_reset(input int start);
		#1 RSTN = 1'b0;
		phys = start;
		repeat (10) @(posedge CLK);
		#1 RSTN = 1'b1;
		wait_settled();
	endtask
	task automatic t_seek();
		u_host_model.steps(5, 1'b0);
		chk(STAT_OE_N[0], 1);
		wait_settled();
		chk(phys, 5);
		chk(STAT_OE_N[1], 1);
	endtask
	task automatic t_unsel();
		#1 u_host_model.unit_sel_n = 4'hE;
		u_host_model.steps(3, 1'b0);
		repeat (5) @(posedge CLK);
		chk(STAT_OE_N, 5'h1F);
		chk(phys, 5);
		#1 SELECT_CFG = 2'd0;
		repeat (5) @(posedge CLK);
		chk(STAT_OE_N[0], 0);
		#1 SELECT_CFG = 2'd2;
		u_host_model.unit_sel_n = 4'hB;
	endtask
	task automatic t_heads();
		for (int h = 0; h < 7; h++) begin
			#1 u_host_model.head_sel_n = ~h[2:0];
			INDEX_SENSE_N = h[0];
			repeat (6) @(posedge CLK);
			chk(HEAD_NUM, h);
			chk(STAT_OE_N[3], h[0]);
		end
		host_write();
		repeat (5) @(posedge CLK);
		chk({WRITE_MODE, WRITE_DRIVE}, 2'b11);
		#1 u_host_model.we_n = 1'b1;
		repeat (5) @(posedge CLK);
		chk({WRITE_MODE, WRITE_DRIVE}, 2'b00);
	endtask
	task automatic t_lie();
		u_host_model.steps(2, 1'b1);
		wait_settled();
		#1 phys = 5;
		u_host_model.steps(3, 1'b1);
		wait_settled();
		chk(phys, 0);
		chk(STAT_OE_N[1], 0);
	endtask
	task automatic t_clamp();
		for (int m = 0; m < 2; m++) begin
			#1 MODEL_LARGE = m[0];
			u_host_model.steps(1200, 1'b0);
			wait_settled();
			chk(phys, m ? 1167 : 1003);
			u_host_model.steps(1200, 1'b1);
			wait_settled();
			chk(phys, 0);
		end
	endtask
	task automatic t_fault();
		for (int k = 0; k < 4; k++) begin
			do_reset(0);
			host_write();
			repeat (5) @(posedge CLK);
			chk(WRITE_DRIVE, 1);
			#1 {OFF_TRACK, HEAD_OPEN, HEAD_SHORT} = 3'b100 >> k;
			WRITE_CURRENT_OK = (k != 3);
			repeat (6) @(posedge CLK);
			chk({STAT_OE_N[2], WRITE_DRIVE}, 2'b00);
			#1 u_host_model.we_n = 1'b1;
			u_host_model.head_sel_n = 3'h6;
			repeat (6) @(posedge CLK);
			chk(STAT_OE_N[2], 1);
			chk(u_host_model.fault_q, 1);
			u_host_model.steps(2, 1'b0);
			repeat (30) @(posedge CLK);
			chk(phys, 0);
			chk(HEAD_NUM, 6);
			#1 {OFF_TRACK, HEAD_OPEN, HEAD_SHORT, WRITE_CURRENT_OK} = 4'h1;
			u_host_model.head_sel_n = 3'h1;
		end
	endtask
	// Supply or speed loss: settled and ready drop, writing faults
	task automatic t_power();
		for (int p = 0; p < 2; p++) begin
			#1 {SUPPLY_OK, SPEED_OK} = p ? 2'b01 : 2'b10;
			repeat (6) @(posedge CLK);
			chk({STAT_OE_N[4], STAT_OE_N[0]}, 2'b11);
			chk(STAT_OUT, 5'h00);
			#1 u_host_model.we_n = 1'b0;
			repeat (6) @(posedge CLK);
			chk({STAT_OE_N[2], WRITE_DRIVE}, 2'b00);
			#1 {SUPPLY_OK, SPEED_OK, u_host_model.we_n} = 3'b111;
			repeat (2) @(posedge CLK);
			do_reset(2);
			chk(phys, 0);
		end
	endtask
	// Main sequence
	initial begin
		{CLK, RSTN, ACT_DONE, OFF_TRACK, HEAD_OPEN, HEAD_SHORT} = 6'h00;
		{WRITE_CURRENT_OK, SUPPLY_OK, SPEED_OK, INDEX_SENSE_N} = 4'hF;
		{SELECT_CFG, MODEL_LARGE, failures, n_tests} = '0;
		SELECT_CFG = 2'd2;
		do_reset(3);
		chk(phys, 0);
		chk(STAT_OE_N[1] | STAT_OE_N[4], 0);
		t_seek();
		t_unsel();
		t_heads();
		t_lie();
		t_clamp();
		t_power();
		t_fault();
		wrap_up();
	end
endmodule
`default_nettype wire
